// [rtl/bch_bus_unit.sv]
/*
 * Bus unit handshake: turns core requests into single, burst or line fill
 * cycles, using burst-ready, ready and cache-enable from memory logic.
 * Assumes pins are asynchronous (synchronised here) and memory logic
 * drives cache_enable_n and both ready inputs as the protocol expects.
 */
// Overview of operation
// [R1] Burst only if longer than bus and burst-ready
// [R2] Burst proceeds regardless of cache-enable level
// [R3] Code/cacheable 16, descriptor/float 8, narrow write 4
// [R4] Narrow write burst continues without address strobe
// [R5] Writes never exceed four bytes
// [R6] Memory bursts only main memory reads
// [R7] Memory ends writes and slow cycles with ready
// [R8] Only code and data reads heed cache-enable
// [R9] Cache-enable active clock before first burst-ready
// [R10] Cache-enable before last flag decides caching
// [R11] Cache-enable converts four-byte read to line
// [R12] Code and 8-byte loads burst without cache-enable
// [R13] Cache-enable valid in first second bus state
// [R14] Memory synchronises cache-enable decode, three clocks
// [R15] Normally-active cache-enable dropped in third state
// [R16] Slow devices drop cache-enable before ready
// [R17] Dynamic sizing 32/16/8, narrow variant 16 only
// [R18] Line fill is four burst-ready doubleword transfers
`timescale 1ns/1ps
module bch_bus_unit #(
    parameter logic NARROW_ONLY = 1'b0
) (
    input  wire logic            sys_clk,
    input  wire logic            rst,
    input  wire logic            req_valid,
    input  wire bch_pkg::bch_req_s req,
    output logic                 req_ready,
    output bch_pkg::bch_rsp_s    rsp,
    output logic                 address_strobe_n,
    output logic                 last_transfer_n,
    output logic [31:0]          bus_addr,
    output logic                 bus_write,
    output logic [31:0]          bus_wdata,
    input  wire logic            ready_n,
    input  wire logic            burst_ready_n,
    input  wire logic            cache_enable_n,
    input  wire logic            bus_size16_n,
    input  wire logic            bus_size8_n,
    input  wire logic [31:0]     data_in
);
    import bch_pkg::*;

    // Bytes requested for each kind of cycle
    function automatic logic [4:0] kind_len(input bch_kind_e k);
        unique case (k)
            KIND_CODE:            kind_len = LEN_CODE;  // [R3] [R12]
            KIND_DESC, KIND_FPU:  kind_len = LEN_EIGHT; // [R3] [R12]
            KIND_WRITE:           kind_len = LEN_WORD;  // [R5]
            default:              kind_len = LEN_WORD;
        endcase
    endfunction : kind_len

    // Only code and data reads may become cached lines
    function automatic logic cacheable(input bch_kind_e k);
        cacheable = (k == KIND_CODE) || (k == KIND_DATA_RD); // [R8]
    endfunction : cacheable

    // Cacheable kind that memory marked with cache-enable
    function automatic logic line_start(input bch_kind_e k, input logic ken);
        line_start = cacheable(k) && ken; // [R8] [R11]
    endfunction : line_start

    // Bytes per transfer from the bus-size pins
    function automatic logic [4:0] bus_bytes(input logic b16_n, input logic b8_n);
        if (!b8_n && !NARROW_ONLY) begin
            bus_bytes = BUS_W8;
        end else if (!b16_n || NARROW_ONLY) begin
            bus_bytes = BUS_W16; // [R17]
        end else begin
            bus_bytes = BUS_W32;
        end
    endfunction : bus_bytes

    bch_st_s     cur_ff;
    bch_st_s     nxt_st;
    bch_pin_s    pin;
    logic [31:0] data_sync;
    logic        ken_act;
    logic        term;
    logic [4:0]  wid;
    logic [4:0]  eff_rem;
    logic [4:0]  after;
    logic [4:0]  proj;

    // Control pins through four flops (three stages and the output)
    bch_sync #(
        .W       (PIN_W),
        .RST_VAL (PIN_IDLE)
    ) u_pin_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .d       ({ready_n, burst_ready_n, cache_enable_n, bus_size16_n, bus_size8_n}),
        .q       (pin)
    );

    // Read data with the same latency as the ready pins
    bch_sync #(
        .W       (32),
        .RST_VAL (DATA_RST)
    ) u_data_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .d       (data_in),
        .q       (data_sync)
    );

    // Next-state logic
    always_comb begin
        nxt_st           = cur_ff;
        nxt_st.ads_n     = 1'b1;
        nxt_st.rsp       = '0;
        ken_act          = ~pin.ken_n;
        nxt_st.ken_prev  = ken_act;
        // Pins lag a strobe by the memory's own edge and the synchroniser,
        // so terminations seen in that window still belong to the last piece;
        // they are ignored, as is the address-strobe clock itself
        if (cur_ff.blind != 3'h0) begin
            nxt_st.blind = 3'(cur_ff.blind - 3'h1);
        end
        term             = cur_ff.ads_n && (cur_ff.blind == 3'h0) && (!pin.rdy_n || !pin.burst_ready_n_n);
        wid              = bus_bytes(pin.bs16_n, pin.bs8_n);
        // Cache-enable in the clock before termination widens the cycle
        eff_rem          = cur_ff.rem;
        if (cur_ff.first && line_start(cur_ff.kind, cur_ff.ken_prev)) begin
            eff_rem = LEN_LINE; // [R11] [R18]
        end
        after            = (eff_rem > wid) ? 5'(eff_rem - wid) : 5'h00;
        proj             = cur_ff.rem;
        unique case (cur_ff.state)
            ST_IDLE: begin
                if (req_valid) begin
                    nxt_st.state     = ST_DATA;
                    nxt_st.kind      = req.kind;
                    nxt_st.addr      = req.addr;
                    nxt_st.wdata     = req.wdata;
                    nxt_st.rem       = kind_len(req.kind);
                    nxt_st.first     = 1'b1;
                    nxt_st.line_mode = 1'b0;
                    nxt_st.cache_ok  = 1'b0;
                    nxt_st.ads_n     = 1'b0;
                    nxt_st.blind     = TERM_BLIND;
                    nxt_st.req_ready = 1'b0;
                    proj             = kind_len(req.kind);
                end
            end
            ST_DATA: begin
                if (!cur_ff.first || !cacheable(cur_ff.kind) || !ken_act) begin
                    proj = cur_ff.rem;
                end else begin
                    proj = LEN_LINE; // [R11]
                end
                if (term) begin
                    nxt_st.rsp.valid = 1'b1;
                    nxt_st.rsp.data  = data_sync;
                    if (cur_ff.first) begin
                        // Line status fixed at first transfer, code or data read
                        nxt_st.line_mode = line_start(cur_ff.kind, cur_ff.ken_prev); // [R8]
                    end
                    nxt_st.first = 1'b0;
                    nxt_st.rem   = after;
                    nxt_st.addr  = 32'(cur_ff.addr + {27'h0, wid});
                    proj         = after;
                    if (after == 5'h00) begin
                        nxt_st.state          = ST_IDLE;
                        nxt_st.req_ready      = 1'b1;
                        nxt_st.rsp.last       = 1'b1;
                        nxt_st.rsp.cache_fill = (cur_ff.first ? line_start(cur_ff.kind, cur_ff.ken_prev)
                                                 : cur_ff.line_mode) && cur_ff.cache_ok; // [R10]
                    end else if (pin.burst_ready_n_n || !pin.rdy_n) begin
                        // Plain ready ends this piece; next piece needs a new strobe
                        nxt_st.ads_n = 1'b0; // [R1]
                        nxt_st.blind = TERM_BLIND;
                    end
                    // Otherwise burst-ready with bytes left: keep going, no strobe,
                    // whatever cache-enable shows [R1] [R2] [R4] [R18]
                end
            end
            default: begin
                nxt_st.state = ST_IDLE;
            end
        endcase
        // Last-transfer flag for the coming clock
        nxt_st.last_transfer_n_n = !((nxt_st.state == ST_DATA) && (proj <= wid));
        // Write marker registered with the cycle
        nxt_st.bus_wr  = (nxt_st.kind == KIND_WRITE) && (nxt_st.state == ST_DATA);
        // Cache-enable seen the clock before the flag goes active
        if (cur_ff.last_transfer_n_n && !nxt_st.last_transfer_n_n) begin
            nxt_st.cache_ok = ken_act; // [R10]
        end
    end

    // State register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cur_ff <= '{state: ST_IDLE, kind: KIND_CODE, addr: 32'h0000_0000,
                        wdata: 32'h0000_0000, rem: 5'h00, first: 1'b0,
                        ken_prev: 1'b0, line_mode: 1'b0, cache_ok: 1'b0,
                        ads_n: 1'b1, last_transfer_n_n: 1'b1, req_ready: 1'b1,
                        blind: 3'h0, bus_wr: 1'b0, rsp: '0};
        end else begin
            cur_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register
    assign req_ready        = cur_ff.req_ready;
    assign rsp              = cur_ff.rsp;
    assign address_strobe_n = cur_ff.ads_n;
    assign last_transfer_n  = cur_ff.last_transfer_n_n;
    assign bus_addr         = cur_ff.addr;
    assign bus_write        = cur_ff.bus_wr;
    assign bus_wdata        = cur_ff.wdata;

endmodule : bch_bus_unit

// [rtl/bch_pkg.sv]
/*
 * Shared types and constants for the burst and cache-enable bus handshake.
 * Assumes one bus clock; pins are synchronised inside the block.
 */
package bch_pkg;

    // Cycle lengths in bytes
    localparam logic [4:0] LEN_LINE   = 5'h10;
    localparam logic [4:0] LEN_CODE   = 5'h10;
    localparam logic [4:0] LEN_EIGHT  = 5'h08;
    localparam logic [4:0] LEN_WORD   = 5'h04;
    // Bytes carried per transfer for each bus width
    localparam logic [4:0] BUS_W32    = 5'h04;
    localparam logic [4:0] BUS_W16    = 5'h02;
    localparam logic [4:0] BUS_W8     = 5'h01;
    // Synchroniser depth for pin inputs
    localparam int         SYNC_DEPTH = 3;
    // Clocks after a strobe in which pin terminations are stale
    localparam logic [2:0] TERM_BLIND = 3'h5;
    // Pin group width and idle level (all inputs inactive high)
    localparam int         PIN_W      = 5;
    localparam logic [4:0] PIN_IDLE   = 5'h1f;
    localparam logic [31:0] DATA_RST  = 32'h0000_0000;

    // Kinds of cycle the core may request
    typedef enum logic [2:0] {
        KIND_CODE,
        KIND_DATA_RD,
        KIND_DESC,
        KIND_FPU,
        KIND_IO_RD,
        KIND_LOCK_RD,
        KIND_WRITE
    } bch_kind_e;

    typedef enum logic {
        ST_IDLE,
        ST_DATA
    } bch_state_e;

    // Request from the core
    typedef struct packed {
        bch_kind_e   kind;
        logic [31:0] addr;
        logic [31:0] wdata;
    } bch_req_s;

    // One answer per transfer
    typedef struct packed {
        logic        valid;
        logic        last;
        logic        cache_fill;
        logic [31:0] data;
    } bch_rsp_s;

    // Synchronised pins
    typedef struct packed {
        logic rdy_n;
        logic burst_ready_n_n;
        logic ken_n;
        logic bs16_n;
        logic bs8_n;
    } bch_pin_s;

    // Whole state of the bus unit
    typedef struct packed {
        bch_state_e  state;
        bch_kind_e   kind;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [4:0]  rem;
        logic        first;
        logic        ken_prev;
        logic        line_mode;
        logic        cache_ok;
        logic        ads_n;
        logic        last_transfer_n_n;
        logic        req_ready;
        logic [2:0]  blind;
        logic        bus_wr;
        bch_rsp_s    rsp;
    } bch_st_s;

endpackage : bch_pkg

// [rtl/bch_sync.sv]
/*
 * Three-stage pin synchroniser; a bit changes once stages two and three agree.
 * Assumes inputs are asynchronous to sys_clk.
 */
`timescale 1ns/1ps
module bch_sync #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    import bch_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } bch_sync_st_s;

    bch_sync_st_s cur_ff;
    bch_sync_st_s nxt_st;
    logic [W-1:0] diff;

    // Shift chain; output follows only agreeing bits
    always_comb begin
        nxt_st    = cur_ff;
        nxt_st.s1 = d;
        nxt_st.s2 = cur_ff.s1;
        nxt_st.s3 = cur_ff.s2;
        diff      = cur_ff.s2 ^ cur_ff.s3;
        nxt_st.q  = (cur_ff.s3 & ~diff) | (cur_ff.q & diff);
    end

    // State register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cur_ff <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else begin
            cur_ff <= nxt_st;
        end
    end

    assign q = cur_ff.q;

endmodule : bch_sync

// [testbench/bch_bus_unit_properties.sv]
/* Port checker for the bus unit handshake.
   Assumes one bus clock and the async active high reset. */
`timescale 1ns/1ps
module bch_bus_unit_properties (
    input wire logic              sys_clk,
    input wire logic              rst,
    input wire logic              req_valid,
    input wire bch_pkg::bch_req_s req,
    input wire logic              req_ready,
    input wire bch_pkg::bch_rsp_s rsp,
    input wire logic              address_strobe_n,
    input wire logic              last_transfer_n,
    input wire logic [31:0]       bus_addr,
    input wire logic              bus_write
);
    import bch_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Acceptance starts a strobe with the request's address
    a_take_strobe: assert property (req_valid && req_ready |=> !req_ready && !address_strobe_n)
        else $error("no strobe after request");
    a_strobe_addr: assert property (req_valid && req_ready |=> bus_addr == $past(req.addr)
        && bus_write == ($past(req.kind) == KIND_WRITE)) else $error("strobe address wrong");
    a_strobe_pulse: assert property (!address_strobe_n |=> address_strobe_n)
        else $error("strobe longer than a clock");
    a_rsp_gap: assert property (req_valid && req_ready |=> !rsp.valid [*2])
        else $error("answer too early");
    // Answers only inside a cycle, last one frees the core side
    a_rsp_busy: assert property (rsp.valid |-> !$past(req_ready))
        else $error("answer while idle");
    a_idle_quiet: assert property (req_ready && $past(req_ready) |-> !rsp.valid)
        else $error("answer during idle");
    a_last_flag: assert property (rsp.valid && rsp.last |-> req_ready && !$past(last_transfer_n))
        else $error("final transfer not flagged");
    a_fill_last: assert property (rsp.valid && rsp.cache_fill |-> rsp.last)
        else $error("fill flag before last");
    a_write_nofill: assert property (rsp.valid && $past(bus_write) |-> !rsp.cache_fill)
        else $error("write marked cacheable");
endmodule : bch_bus_unit_properties

bind bch_bus_unit bch_bus_unit_properties u_bch_bus_unit_properties (
    .sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp(rsp), .address_strobe_n(address_strobe_n),
    .last_transfer_n(last_transfer_n), .bus_addr(bus_addr), .bus_write(bus_write)
);

// [testbench/bch_mem_model.sv]
/* Memory logic model answering the bus unit pins.
   Assumes the bench releases it with done after the final answer. */
`timescale 1ns/1ps
module bch_mem_model #(
    parameter logic [31:0] DATA_KEY = 32'h5a5a_0000
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        address_strobe_n,
    input  wire logic [31:0] bus_addr,
    input  wire logic [3:0]  wait_cnt,
    input  wire logic [3:0]  ken_len,
    input  wire logic        use_burst,
    input  wire logic [1:0]  narrow,
    input  wire logic        done,
    output logic             ready_n,
    output logic             burst_ready_n,
    output logic             cache_enable_n,
    output logic             bus_size16_n,
    output logic             bus_size8_n,
    output logic [31:0]      data_in
);
    logic        busy_ff;
    logic [3:0]  cnt_ff;
    logic [31:0] addr_ff;
    logic        term;
    // Follow the cycle from each strobe
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            busy_ff <= 1'b0;
            cnt_ff  <= 4'h0;
            addr_ff <= 32'h0000_0000;
        end else if (!address_strobe_n) begin
            busy_ff <= 1'b1;
            cnt_ff  <= 4'h0;
            addr_ff <= bus_addr;
        end else if (done) begin
            busy_ff <= 1'b0;
        end else if (busy_ff && cnt_ff != 4'hf) begin
            cnt_ff <= cnt_ff + 4'h1;
        end
    end
    // Termination held after the wait states, data inverted when not driven
    assign term           = busy_ff && (cnt_ff >= wait_cnt);
    assign ready_n        = !(term && !use_burst);
    assign burst_ready_n  = !(term && use_burst);
    assign cache_enable_n = !(ken_len != 4'h0 && (!busy_ff || cnt_ff < ken_len));
    assign bus_size16_n   = (narrow == 2'h0);
    assign bus_size8_n    = (narrow != 2'h2);
    assign data_in        = term ? (DATA_KEY ^ addr_ff) : ~(DATA_KEY ^ addr_ff);
endmodule : bch_mem_model

// [testbench/burst_cache_enable_handshake_test.sv]
/* Self-checking bench for the bus unit handshake.
   Drives the core side; the memory model answers the pins. */
`timescale 1ns/1ps
module burst_cache_enable_handshake_test;
    import bch_pkg::*;
    localparam logic [31:0] KEY  = 32'h5a5a_0000;
    localparam logic [31:0] ADDR = 32'h0000_2040;
    logic        sys_clk, rst, req_valid, req_ready, done, use_burst;
    logic        address_strobe_n, last_transfer_n, bus_write;
    logic        ready_n, burst_ready_n, cache_enable_n, bus_size16_n, bus_size8_n;
    logic [31:0] bus_addr, bus_wdata, data_in;
    logic [3:0]  wait_cnt, ken_len;
    logic [1:0]  narrow;
    bch_req_s    req;
    bch_rsp_s    rsp;
    int          error_cnt, comparisons, cycles;

    bch_bus_unit u_bch_bus_unit (
        .sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rsp(rsp), .address_strobe_n(address_strobe_n), .last_transfer_n(last_transfer_n),
        .bus_addr(bus_addr), .bus_write(bus_write), .bus_wdata(bus_wdata), .ready_n(ready_n),
        .burst_ready_n(burst_ready_n), .cache_enable_n(cache_enable_n),
        .bus_size16_n(bus_size16_n), .bus_size8_n(bus_size8_n), .data_in(data_in)
    );
    bch_mem_model #(.DATA_KEY(KEY)) u_bch_mem_model (
        .sys_clk(sys_clk), .rst(rst), .address_strobe_n(address_strobe_n), .bus_addr(bus_addr),
        .wait_cnt(wait_cnt), .ken_len(ken_len), .use_burst(use_burst), .narrow(narrow),
        .done(done), .ready_n(ready_n), .burst_ready_n(burst_ready_n),
        .cache_enable_n(cache_enable_n), .bus_size16_n(bus_size16_n),
        .bus_size8_n(bus_size8_n), .data_in(data_in)
    );

    // Bus clock, 4 ns
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 4000) begin
            error_cnt++;
            summarize();
        end
    end

    task automatic summarize();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One bus cycle: set memory, request, count answers and strobes
    task automatic run(input bch_kind_e k, input logic [3:0] w, input logic b, input logic [3:0] kl,
                       input logic [1:0] nw, input int n, input int s, input logic f);
        int          nr;
        int          ns;
        logic        fill;
        logic [31:0] d;
        logic [31:0] wb;
        nr = 0;
        ns = 0;
        fill = 1'b0;
        d = '0;
        wb = (nw == 2'h0) ? 32'(BUS_W32) : ((nw == 2'h1) ? 32'(BUS_W16) : 32'(BUS_W8));
        wait_cnt = w;
        use_burst = b;
        ken_len = kl;
        narrow = nw;
        repeat (8) @(posedge sys_clk);
        #1;
        req = '{kind: k, addr: ADDR, wdata: ~KEY};
        req_valid = 1'b1;
        @(posedge sys_clk);
        #1;
        req_valid = 1'b0;
        repeat (300) begin
            @(negedge sys_clk);
            ns += int'(!address_strobe_n);
            if (rsp.valid === 1'b1) begin
                nr++;
                d = rsp.data;
                fill = rsp.cache_fill;
            end
            if (rsp.valid === 1'b1 && rsp.last === 1'b1) break;
        end
        @(posedge sys_clk);
        #1;
        done = 1'b1;
        @(posedge sys_clk);
        #1;
        done = 1'b0;
        check(32'(nr), 32'(n));
        check(32'(ns), 32'(s));
        check({31'h0, fill}, {31'h0, f});
        if (n == 1 && k != KIND_WRITE) check(d, KEY ^ ADDR);
        if (k == KIND_WRITE) check(bus_wdata, ~KEY);
        check(bus_addr, ADDR + 32'(n) * wb);
    endtask : run

    // Bursts without cache-enable, pieces on ready, plain write
    task automatic t_plain_bursts();
        run(KIND_CODE, 4'h1, 1'b1, 4'h0, 2'h0, 4, 1, 1'b0);
        run(KIND_DESC, 4'h1, 1'b1, 4'h0, 2'h0, 2, 1, 1'b0);
        run(KIND_FPU, 4'h1, 1'b0, 4'h0, 2'h0, 2, 2, 1'b0);
        run(KIND_WRITE, 4'h1, 1'b0, 4'hf, 2'h0, 1, 1, 1'b0);
    endtask : t_plain_bursts

    // Cache-enable on code, data, I/O and locked reads
    task automatic t_cache_kinds();
        run(KIND_DATA_RD, 4'h1, 1'b1, 4'hf, 2'h0, 4, 1, 1'b1);
        run(KIND_DATA_RD, 4'h1, 1'b1, 4'h0, 2'h0, 1, 1, 1'b0);
        run(KIND_CODE, 4'h1, 1'b1, 4'hf, 2'h0, 4, 1, 1'b1);
        run(KIND_IO_RD, 4'h1, 1'b1, 4'hf, 2'h0, 1, 1, 1'b0);
        run(KIND_LOCK_RD, 4'h1, 1'b1, 4'hf, 2'h0, 1, 1, 1'b0);
    endtask : t_cache_kinds

    // Narrow buses, both size pins low means 8-bit
    task automatic t_narrow_bus();
        run(KIND_WRITE, 4'h1, 1'b1, 4'h0, 2'h1, 2, 1, 1'b0);
        run(KIND_CODE, 4'h1, 1'b1, 4'h0, 2'h2, 16, 1, 1'b0);
    endtask : t_narrow_bus

    // Slow device drops cache-enable before terminating
    task automatic t_slow_device();
        run(KIND_DATA_RD, 4'h6, 1'b1, 4'h2, 2'h0, 1, 1, 1'b0);
    endtask : t_slow_device

    // Reset, then the scenarios
    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        done = 1'b0;
        use_burst = 1'b0;
        wait_cnt = 4'h0;
        ken_len = 4'h0;
        narrow = 2'h0;
        req = '0;
        repeat (16) @(posedge sys_clk);
        @(negedge sys_clk);
        check({28'h0, req_ready, address_strobe_n, last_transfer_n, rsp.valid}, 32'h0000_000e);
        @(posedge sys_clk);
        #1;
        rst = 1'b0;
        t_plain_bursts();
        t_cache_kinds();
        t_narrow_bus();
        t_slow_device();
        summarize();
    end
endmodule : burst_cache_enable_handshake_test
